// ---- rtl/cfs_defs.svh ----
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
`define CFS_ROOT_TYPE    8'h3f
`define CFS_DIR_TYPE     8'h7f
`define CFS_ROOT_DATA    8'h2f
`define CFS_DIR_DATA     8'h6f
`define CFS_ROOT_ID      16'h3f00
`define CFS_ADM_DIR_HI   4'h4
`define CFS_OPS_DIR_HI   4'h2
`define CFS_OPS_DIR_1X   8'h10
`define CFS_ROOT_ADM_01  8'h01
`define CFS_ROOT_ADM_HI  4'he
`define CFS_ROOT_OPS_HI  4'h1
`define CFS_NO_REC       8'h00
`define CFS_FIRST_REC    8'h01
`define CFS_ENTRIES      16
`define CFS_IDX_W        4
`define CFS_NONE_IDX     4'hf
`endif

// ---- rtl/cfs_pkg.sv ----
package cfs_pkg;
  typedef enum logic [1:0] {
    CFS_DIR_KIND = 2'h0,
    CFS_TRANSP   = 2'h1,
    CFS_LINEAR   = 2'h2,
    CFS_CYCLIC   = 2'h3
  } cfs_struct_type;

  typedef enum logic [2:0] {
    CFS_OP_SELECT = 3'h0,
    CFS_OP_NEXT   = 3'h1,
    CFS_OP_PREV   = 3'h2,
    CFS_OP_CURR   = 3'h3,
    CFS_OP_ABS    = 3'h4,
    CFS_OP_SEEK   = 3'h5,
    CFS_OP_ABORT  = 3'h6,
    CFS_OP_APP    = 3'h7
  } cfs_op_type;

  typedef enum logic [1:0] {
    CFS_SK_FWD_START = 2'h0,
    CFS_SK_FWD_NEXT  = 2'h1,
    CFS_SK_BWD_END   = 2'h2,
    CFS_SK_BWD_PREV  = 2'h3
  } cfs_seek_type;

  typedef enum logic [1:0] {
    CFS_RPT_NONE = 2'h0,
    CFS_RPT_SET  = 2'h1,
    CFS_RPT_ERR  = 2'h3
  } cfs_result_type;

  // One directory entry, fixed at personalisation
  typedef struct packed {
    logic           used;
    logic [15:0]    id;
    logic [3:0]     parent;
    cfs_struct_type kind;
    logic [15:0]    body_len;
    logic [7:0]     rec_len;
    logic [7:0]     rec_cnt;
    logic [7:0]     app_tag;
  } cfs_entry_type;

  typedef struct packed {
    cfs_op_type     op;
    logic [15:0]    file_id;
    logic [7:0]     rec_num;
    cfs_seek_type   seek;
    logic [7:0]     seek_hit;
    logic           is_update;
    logic [7:0]     app_tag;
  } cfs_cmd_type;

  typedef struct packed {
    logic           ok;
    logic           reject;
    logic [7:0]     record;
    logic [7:0]     seek_from;
    logic           seek_back;
    logic [15:0]    cur_dir;
    logic [15:0]    cur_file;
    logic           file_valid;
    cfs_struct_type kind;
    logic [15:0]    body_len;
    logic [7:0]     rec_len;
    logic [15:0]    total_len;
  } cfs_resp_type;
endpackage : cfs_pkg

// ---- rtl/cfs_table.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.svh"
// Header store: written only in the administrative phase
module cfs_table
  import cfs_pkg::*;
(
  // Clock
  input  wire logic                  clock,
  // Write side
  input  wire logic                  wr_en,
  input  wire logic [`CFS_IDX_W-1:0] wr_idx,
  input  wire cfs_entry_type         wr_data,
  // Whole table view
  output cfs_entry_type              tab [`CFS_ENTRIES]
);
  cfs_entry_type mem [`CFS_ENTRIES];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    tab <= mem;
  end
endmodule : cfs_table
`default_nettype wire

// ---- rtl/cfs_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.svh"
module cfs_core
  import cfs_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  SYS_RST,
  // Answer-to-reset done pulse
  input  wire logic                  ATR_DONE,
  // Administrative header load
  input  wire logic                  ADM_PHASE,
  input  wire logic                  HDR_WR,
  input  wire logic [`CFS_IDX_W-1:0] HDR_IDX,
  input  wire cfs_entry_type         HDR_DATA,
  // Command
  input  wire logic                  CMD_VALID,
  input  wire cfs_cmd_type           CMD,
  // Answer
  output cfs_resp_type               RESP,
  output logic                       RESP_VALID
);
  default clocking cfs_cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  cfs_entry_type         tab [`CFS_ENTRIES];
  logic [`CFS_IDX_W-1:0] cur_dir;
  logic [`CFS_IDX_W-1:0] cur_file;
  logic [`CFS_IDX_W-1:0] last_sel;
  logic [7:0]            ptr;
  logic [7:0]            saved_ptr;
  logic [7:0]            cyc_last [`CFS_ENTRIES];
  logic                  ready;

  cfs_table u_table (
    .clock   (CLOCK),
    .wr_en   (HDR_WR && ADM_PHASE),
    .wr_idx  (HDR_IDX),
    .wr_data (HDR_DATA),
    .tab     (tab)
  );

  function automatic logic reserved_id(input logic [15:0] id);
    logic [7:0] lo;
    lo = id[7:0];
    reserved_id = 1'b0;
    if (id[15:8] == `CFS_DIR_TYPE) begin
      reserved_id = (lo[7:4] == `CFS_ADM_DIR_HI)
                 || (lo[7:4] == `CFS_OPS_DIR_HI)
                 || (lo == `CFS_OPS_DIR_1X);
    end else if (id[15:8] == `CFS_ROOT_DATA) begin
      reserved_id = (lo == `CFS_ROOT_ADM_01)
                 || (lo[7:4] == `CFS_ROOT_ADM_HI)
                 || (lo[7:4] == `CFS_ROOT_OPS_HI);
    end
  endfunction : reserved_id

  // Lookup by ID, and by parent unless any_par is set; reserved IDs are still refused by the select check even when populated
  function automatic logic [4:0] find(input logic [15:0] id,
                                      input logic [3:0] par,
                                      input logic any_par);
    find = {1'b0, `CFS_NONE_IDX};
    for (int i = 0; i < `CFS_ENTRIES; i++) begin
      if (tab[i].used && tab[i].id == id && (any_par || tab[i].parent == par))
        find = {1'b1, 4'(i)};
    end
  endfunction : find

  // Type byte must match position in tree
  function automatic logic type_ok(input logic [3:0] i);
    logic [7:0] hi;
    hi = tab[i].id[15:8];
    if (tab[i].kind == CFS_DIR_KIND)
      type_ok = (tab[i].id == `CFS_ROOT_ID) || (hi == `CFS_DIR_TYPE);
    else if (tab[tab[i].parent].id == `CFS_ROOT_ID)
      type_ok = (hi == `CFS_ROOT_DATA);
    else
      type_ok = (hi == `CFS_DIR_DATA);
  endfunction : type_ok

  // Ancestor collision check over a two-level tree
  function automatic logic clash(input logic [3:0] i);
    logic [3:0] p;
    logic [3:0] g;
    p = tab[i].parent;
    g = tab[p].parent;
    clash = p != `CFS_NONE_IDX && (tab[p].id == tab[i].id
         || (g != `CFS_NONE_IDX && g != p && tab[g].id == tab[i].id));
  endfunction : clash

  logic [4:0]  hit;
  logic [4:0]  root_hit;
  logic [3:0]  hi_idx;
  logic [3:0]  root_idx;
  logic        legal;
  logic        dup;
  logic [7:0]  n;
  logic        is_cyc;
  logic        is_rec;
  logic [7:0]  next_ptr;
  logic        next_ok;
  logic [7:0]  next_seek;
  logic        seek_back;

  always_comb begin
    root_hit = find(`CFS_ROOT_ID, 4'h0, 1'b1);
    root_idx = root_hit[3:0];
    hit      = find(CMD.file_id, 4'h0, 1'b1);
    hi_idx   = hit[3:0];
    dup      = 1'b0;
    for (int j = 0; j < `CFS_ENTRIES; j++) begin
      if (tab[j].used && 4'(j) != hi_idx && tab[j].id == CMD.file_id
          && tab[j].parent == tab[hi_idx].parent)
        dup = 1'b1;
    end
    legal = hit[4] && !dup && type_ok(hi_idx) && !clash(hi_idx)
         && !reserved_id(CMD.file_id)
         && ( tab[hi_idx].parent == cur_dir
           || (tab[hi_idx].kind == CFS_DIR_KIND
               && tab[hi_idx].parent == tab[cur_dir].parent)
           || hi_idx == tab[cur_dir].parent
           || hi_idx == cur_dir
           || hi_idx == root_idx
           || hi_idx == last_sel);
  end

  // Record pointer movement
  always_comb begin
    n         = tab[cur_file].rec_cnt;
    is_cyc    = tab[cur_file].kind == CFS_CYCLIC;
    is_rec    = cur_file != `CFS_NONE_IDX && (is_cyc
                || tab[cur_file].kind == CFS_LINEAR);
    next_ptr  = ptr;
    next_ok   = is_rec;
    next_seek = `CFS_NO_REC;
    seek_back = 1'b0;
    case (CMD.op)
      CFS_OP_NEXT: begin
        if (is_cyc && CMD.is_update) next_ok = 1'b0;
        else if (ptr == `CFS_NO_REC) next_ptr = `CFS_FIRST_REC;
        else if (ptr == n) begin
          if (is_cyc) next_ptr = `CFS_FIRST_REC;
          else next_ok = 1'b0;
        end else next_ptr = 8'(ptr + 8'h01);
      end
      CFS_OP_PREV: begin
        if (is_cyc && CMD.is_update) next_ptr = `CFS_FIRST_REC;
        else if (ptr == `CFS_NO_REC) next_ptr = n;
        else if (ptr == `CFS_FIRST_REC) begin
          if (is_cyc) next_ptr = n;
          else next_ok = 1'b0;
        end else next_ptr = 8'(ptr - 8'h01);
      end
      CFS_OP_CURR: begin
        next_ok = is_rec && ptr != `CFS_NO_REC && !(is_cyc && CMD.is_update);
      end
      CFS_OP_ABS: begin
        next_ok = is_rec && CMD.rec_num >= `CFS_FIRST_REC
               && CMD.rec_num <= n && !(is_cyc && CMD.is_update);
      end
      CFS_OP_SEEK: begin
        next_ok = is_rec;
        case (CMD.seek)
          CFS_SK_FWD_START: next_seek = `CFS_FIRST_REC;
          CFS_SK_FWD_NEXT: begin
            next_ok   = is_rec && ptr != n;
            next_seek = 8'(ptr + 8'h01);
          end
          CFS_SK_BWD_END: begin
            next_seek = n;
            seek_back = 1'b1;
          end
          CFS_SK_BWD_PREV: begin
            next_ok   = is_rec && ptr > `CFS_FIRST_REC;
            next_seek = 8'(ptr - 8'h01);
            seek_back = 1'b1;
          end
          default: next_ok = 1'b0;
        endcase
        if (next_ok && CMD.seek_hit != `CFS_NO_REC) next_ptr = CMD.seek_hit;
      end
      CFS_OP_ABORT: next_ptr = saved_ptr;
      default: next_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ready    <= 1'b0;
      cur_dir  <= 4'h0;
      cur_file <= `CFS_NONE_IDX;
      last_sel <= 4'h0;
    end else if (ATR_DONE) begin
      ready    <= 1'b1;
      cur_dir  <= root_idx;
      cur_file <= `CFS_NONE_IDX;
      last_sel <= root_idx;
    end else if (CMD_VALID && ready && CMD.op == CFS_OP_SELECT && legal) begin
      last_sel <= hi_idx;
      if (tab[hi_idx].kind == CFS_DIR_KIND) begin
        cur_dir  <= hi_idx;
        cur_file <= `CFS_NONE_IDX;
      end else begin
        cur_dir  <= tab[hi_idx].parent;
        cur_file <= hi_idx;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ptr       <= `CFS_NO_REC;
      saved_ptr <= `CFS_NO_REC;
    end else if (ATR_DONE) begin
      ptr <= `CFS_NO_REC;
    end else if (CMD_VALID && ready) begin
      if (CMD.op == CFS_OP_SELECT && legal) begin
        if (tab[hi_idx].kind == CFS_CYCLIC)
          ptr <= cyc_last[hi_idx];
        else
          ptr <= `CFS_NO_REC;
      end else if (CMD.op == CFS_OP_ABORT) begin
        ptr <= saved_ptr;
      end else if (next_ok && CMD.op != CFS_OP_SELECT) begin
        saved_ptr <= ptr;
        ptr       <= next_ptr;
      end
    end
  end

  // Newest record is always slot one after a cyclic store
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int k = 0; k < `CFS_ENTRIES; k++) cyc_last[k] <= `CFS_FIRST_REC;
    end else if (CMD_VALID && ready && is_cyc && CMD.is_update && next_ok
                 && CMD.op == CFS_OP_PREV) begin
      cyc_last[cur_file] <= `CFS_FIRST_REC;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RESP       <= '0;
      RESP_VALID <= 1'b0;
    end else begin
      RESP_VALID <= CMD_VALID && ready;
      RESP.cur_dir    <= tab[cur_dir].id;
      RESP.cur_file   <= tab[cur_file].id;
      RESP.file_valid <= cur_file != `CFS_NONE_IDX;
      RESP.kind       <= tab[cur_file].kind;
      RESP.body_len   <= tab[cur_file].body_len;
      RESP.rec_len    <= tab[cur_file].rec_len;
      RESP.total_len  <= 16'(tab[cur_file].rec_len * tab[cur_file].rec_cnt);
      RESP.record     <= next_ptr;
      RESP.seek_from  <= next_seek;
      RESP.seek_back  <= seek_back;
      case (CMD.op)
        CFS_OP_SELECT: begin
          RESP.ok     <= legal;
          RESP.reject <= !legal;
        end
        CFS_OP_APP: begin
          RESP.ok     <= CMD.app_tag == tab[cur_dir].app_tag;
          RESP.reject <= CMD.app_tag != tab[cur_dir].app_tag;
        end
        CFS_OP_ABORT: begin
          RESP.ok     <= 1'b1;
          RESP.reject <= 1'b0;
        end
        default: begin
          RESP.ok     <= next_ok;
          RESP.reject <= !next_ok;
        end
      endcase
    end
  end

  sequence bad_sel_s;
    CMD_VALID && ready && CMD.op == CFS_OP_SELECT && !legal && !ATR_DONE;
  endsequence

  atr_root_a: assert property (
    ATR_DONE |=> cur_dir == $past(root_idx) && cur_file == `CFS_NONE_IDX)
    else $error("root not selected after reset answer");
  bad_sel_hold_a: assert property (
    bad_sel_s |=> $stable(cur_dir) && $stable(cur_file) && $stable(ptr))
    else $error("illegal select changed state");
  lin_unset_a: assert property (
    CMD_VALID && ready && CMD.op == CFS_OP_SELECT && legal && !ATR_DONE
    && tab[hi_idx].kind == CFS_LINEAR |=> ptr == `CFS_NO_REC)
    else $error("linear pointer set after select");
  lin_nowrap_a: assert property (
    CMD_VALID && ready && CMD.op == CFS_OP_NEXT && !is_cyc && ptr == n
    && ptr != `CFS_NO_REC |-> !next_ok)
    else $error("linear pointer wrapped");
  cyc_wrap_a: assert property (
    is_rec && is_cyc && CMD.op == CFS_OP_NEXT && !CMD.is_update && ptr == n
    && ptr != `CFS_NO_REC |-> next_ptr == `CFS_FIRST_REC)
    else $error("cyclic pointer did not wrap");
  abort_rest_a: assert property (
    CMD_VALID && ready && CMD.op == CFS_OP_ABORT && !ATR_DONE
    |=> ptr == $past(saved_ptr))
    else $error("abort did not restore pointer");
  resp_next_a: assert property (
    CMD_VALID && ready |=> RESP_VALID ##1 !RESP_VALID || $past(CMD_VALID))
    else $error("answer not one cycle after command");
  unset_first_a: assert property (
    is_rec && CMD.op == CFS_OP_NEXT && ptr == `CFS_NO_REC
    && !(is_cyc && CMD.is_update) |-> next_ptr == `CFS_FIRST_REC)
    else $error("unset next did not pick first record");
endmodule : cfs_core
`default_nettype wire

// ---- verification/cfs_term_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfs_term_model
  import cfs_pkg::*;
(
  // Clock
  input  wire logic         CLOCK,
  // Command side
  output cfs_cmd_type       CMD,
  output logic              CMD_VALID,
  // Answer side
  input  wire cfs_resp_type RESP,
  input  wire logic         RESP_VALID
);
  initial begin
    CMD       = '0;
    CMD_VALID = 1'b0;
  end

  // One command per call, answer sampled one edge later
  task automatic send(input cfs_cmd_type c, output cfs_resp_type r,
                      output logic got);
    cfs_cmd_type t;
    t = c;
    t.is_update = c.is_update & (c.op == CFS_OP_PREV);
    @(posedge CLOCK);
    #1;
    CMD       = t;
    CMD_VALID = 1'b1;
    @(posedge CLOCK);
    #1;
    CMD_VALID = 1'b0;
    // Idle lines never keep the last value
    CMD       = ~t;
    got       = RESP_VALID;
    r         = RESP;
  endtask : send
endmodule : cfs_term_model
`default_nettype wire

// ---- verification/card_file_select_record_pointer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.svh"
module card_file_select_record_pointer_tb_top
  import cfs_pkg::*;
;
  logic          clock;
  logic          sys_rst;
  logic          atr_done;
  logic          adm_phase;
  logic          hdr_wr;
  logic [3:0]    hdr_idx;
  cfs_entry_type hdr_data;
  cfs_cmd_type   cmd;
  logic          cmd_valid;
  cfs_resp_type  resp;
  logic          resp_valid;
  cfs_resp_type  rsp;
  logic          got;
  logic [15:0]   exp_dir;
  logic [15:0]   exp_file;
  logic          exp_fv;
  int            n_fail;
  int            samples_checked;

  always #2 clock = ~clock;

  cfs_core DUT (.CLOCK(clock), .SYS_RST(sys_rst), .ATR_DONE(atr_done),
    .ADM_PHASE(adm_phase), .HDR_WR(hdr_wr), .HDR_IDX(hdr_idx),
    .HDR_DATA(hdr_data), .CMD_VALID(cmd_valid), .CMD(cmd),
    .RESP(resp), .RESP_VALID(resp_valid));

  cfs_term_model term (.CLOCK(clock), .CMD(cmd), .CMD_VALID(cmd_valid),
    .RESP(resp), .RESP_VALID(resp_valid));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic wr_raw(input int i, input cfs_entry_type d);
    @(posedge clock);
    #1;
    hdr_wr   = 1'b1;
    hdr_idx  = i[3:0];
    hdr_data = d;
    @(posedge clock);
    #1;
    hdr_wr   = 1'b0;
  endtask : wr_raw

  task automatic wr_ent(input int i, input logic [15:0] id,
    input logic [3:0] p, input cfs_struct_type k, input logic [15:0] b,
    input logic [7:0] rl, input logic [7:0] rc, input logic [7:0] tg);
    wr_raw(i, '{1'b1, id, p, k, b, rl, rc, tg});
  endtask : wr_ent

  // Answer timing, status and directory state before the command
  task automatic do_cmd(input cfs_op_type op, input logic [15:0] id,
    input cfs_seek_type sk, input logic up, input logic [7:0] tg,
    input logic ok, input int rec);
    cfs_cmd_type c;
    c = '{op, id, 8'($urandom), sk, 8'h00, up, tg};
    term.send(c, rsp, got);
    chk(16'(got), 16'h0001);
    chk(16'(rsp.ok), 16'(ok));
    chk(16'(rsp.reject), 16'(!ok));
    chk(rsp.cur_dir, exp_dir);
    chk(16'(rsp.file_valid), 16'(exp_fv));
    if (exp_fv) chk(rsp.cur_file, exp_file);
    if (rec >= 0) chk(16'(rsp.record), 16'(rec));
    if (ok && op == CFS_OP_SELECT) begin
      if (id[15:8] == `CFS_ROOT_TYPE || id[15:8] == `CFS_DIR_TYPE) begin
        exp_dir = id;
        exp_fv  = 1'b0;
      end else begin
        exp_file = id;
        exp_fv   = 1'b1;
      end
    end
  endtask : do_cmd

  task automatic sel(input logic [15:0] id, input logic ok);
    do_cmd(CFS_OP_SELECT, id, CFS_SK_FWD_START, 1'b0, 8'h00, ok, -1);
  endtask : sel

  task automatic rec_op(input cfs_op_type op, input logic ok, input int r);
    do_cmd(op, 16'h0000, CFS_SK_FWD_START, 1'b0, 8'h00, ok, r);
  endtask : rec_op

  task automatic seek(input cfs_seek_type sk, input logic ok,
                      input int from, input logic back);
    do_cmd(CFS_OP_SEEK, 16'h0000, sk, 1'b0, 8'h00, ok, -1);
    if (ok) chk(16'(rsp.seek_from), 16'(from));
    if (ok) chk(16'(rsp.seek_back), 16'(back));
  endtask : seek

  // Status query: answer shows the file selected just before
  task automatic file_chk(input cfs_struct_type k, input logic [15:0] b,
                          input logic [7:0] rl, input logic [7:0] rc);
    do_cmd(CFS_OP_CURR, 16'h0000, CFS_SK_FWD_START, 1'b0, 8'h00,
           1'b0, -1);
    chk(16'(rsp.kind), 16'(k));
    chk(rsp.body_len, b);
    chk(16'(rsp.rec_len), 16'(rl));
    chk(rsp.total_len, 16'(rl) * 16'(rc));
  endtask : file_chk

  // Expected pointer after a move, -1 when refused
  function automatic int step_exp(input logic cyc, input int p,
                                  input int n, input logic fwd);
    if (p == 0) return fwd ? 1 : n;
    if (fwd) return (p < n) ? p + 1 : (cyc ? 1 : -1);
    return (p > 1) ? p - 1 : (cyc ? n : -1);
  endfunction : step_exp

  task automatic walk(input logic cyc, input int n, input int p0);
    int   p;
    int   q;
    logic fwd;
    p = p0;
    repeat (16) begin
      fwd = 1'($urandom_range(1, 0));
      q   = step_exp(cyc, p, n, fwd);
      rec_op(fwd ? CFS_OP_NEXT : CFS_OP_PREV, q >= 0, q);
      if (q >= 0) p = q;
    end
  endtask : walk

  initial begin
    #20000;
    n_fail++;
    finish_test();
  end

  initial begin
    clock     = 1'b0;
    sys_rst   = 1'b1;
    atr_done  = 1'b0;
    adm_phase = 1'b0;
    hdr_wr    = 1'b0;
    hdr_idx   = 4'h0;
    hdr_data  = '0;
    n_fail    = 0;
    samples_checked = 0;
    exp_dir   = `CFS_ROOT_ID;
    exp_file  = 16'h0000;
    exp_fv    = 1'b0;
    void'($urandom(50));
    repeat (10) @(posedge clock);
    #1;
    chk(16'(resp_valid), 16'h0000);
    chk(resp.cur_dir, 16'h0000);
    sys_rst   = 1'b0;
    adm_phase = 1'b1;
    for (int i = 0; i < 16; i++) wr_raw(i, '0);
    wr_ent(0, 16'h3f00, 4'hf, CFS_DIR_KIND, 16'h0000, 8'h00, 8'h00, 8'h00);
    wr_ent(1, 16'h7f50, 4'h0, CFS_DIR_KIND, 16'h0000, 8'h00, 8'h00, 8'h5a);
    wr_ent(2, 16'h7f60, 4'h0, CFS_DIR_KIND, 16'h0000, 8'h00, 8'h00, 8'h66);
    wr_ent(3, 16'h2f05, 4'h0, CFS_TRANSP, 16'h0123, 8'h00, 8'h00, 8'h00);
    wr_ent(4, 16'h6f3a, 4'h1, CFS_LINEAR, 16'h0032, 8'h0a, 8'h05, 8'h00);
    wr_ent(5, 16'h6f3b, 4'h1, CFS_CYCLIC, 16'h000c, 8'h04, 8'h03, 8'h00);
    wr_ent(6, 16'h6f3d, 4'h2, CFS_LINEAR, 16'hfe01, 8'hff, 8'hff, 8'h00);
    wr_ent(7, 16'h7f41, 4'h0, CFS_DIR_KIND, 16'h0000, 8'h00, 8'h00, 8'h00);
    wr_ent(8, 16'h2f11, 4'h0, CFS_TRANSP, 16'h0010, 8'h00, 8'h00, 8'h00);
    adm_phase = 1'b0;
    // Write outside the administrative phase must be dropped
    wr_ent(3, 16'h2f05, 4'h0, CFS_LINEAR, 16'h0fff, 8'h01, 8'h01, 8'h00);
    @(posedge clock);
    #1;
    atr_done = 1'b1;
    @(posedge clock);
    #1;
    atr_done = 1'b0;
    sel(16'h3f00, 1'b1);
    sel(16'h2f05, 1'b1);
    file_chk(CFS_TRANSP, 16'h0123, 8'h00, 8'h00);
    sel(16'h6f3a, 1'b0);
    sel(16'h7f41, 1'b0);
    sel(16'h2f11, 1'b0);
    sel(16'h7f77, 1'b0);
    sel(16'h7f50, 1'b1);
    $display("Test selection done");
    sel(16'h6f3a, 1'b1);
    file_chk(CFS_LINEAR, 16'h0032, 8'h0a, 8'h05);
    rec_op(CFS_OP_PREV, 1'b1, 5);
    seek(CFS_SK_FWD_NEXT, 1'b0, 0, 1'b0);
    seek(CFS_SK_BWD_END, 1'b1, 5, 1'b1);
    seek(CFS_SK_FWD_START, 1'b1, 1, 1'b0);
    sel(16'h6f3a, 1'b1);
    rec_op(CFS_OP_NEXT, 1'b1, 1);
    seek(CFS_SK_BWD_PREV, 1'b0, 0, 1'b0);
    rec_op(CFS_OP_PREV, 1'b0, -1);
    rec_op(CFS_OP_NEXT, 1'b1, 2);
    seek(CFS_SK_BWD_PREV, 1'b1, 1, 1'b1);
    rec_op(CFS_OP_NEXT, 1'b1, 3);
    rec_op(CFS_OP_ABORT, 1'b1, 2);
    rec_op(CFS_OP_CURR, 1'b1, 2);
    sel(16'h6f3a, 1'b1);
    walk(1'b0, 5, 0);
    $display("Test linear done");
    do_cmd(CFS_OP_APP, 16'h0000, CFS_SK_FWD_START, 1'b0, 8'h5a, 1'b1, -1);
    do_cmd(CFS_OP_APP, 16'h0000, CFS_SK_FWD_START, 1'b0, 8'h66, 1'b0, -1);
    sel(16'h6f3b, 1'b1);
    do_cmd(CFS_OP_PREV, 16'h0000, CFS_SK_FWD_START, 1'b1, 8'h00, 1'b1, 1);
    sel(16'h6f3b, 1'b1);
    rec_op(CFS_OP_CURR, 1'b1, 1);
    walk(1'b1, 3, 1);
    sel(16'h6f3b, 1'b1);
    rec_op(CFS_OP_CURR, 1'b1, 1);
    $display("Test cyclic done");
    sel(16'h7f60, 1'b1);
    sel(16'h6f3d, 1'b1);
    file_chk(CFS_LINEAR, 16'hfe01, 8'hff, 8'hff);
    rec_op(CFS_OP_PREV, 1'b1, 255);
    sel(16'h3f00, 1'b1);
    sel(16'h2f05, 1'b1);
    $display("Test limits done");
    // Second reset in mid-run: root again, data file dropped
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(16'(resp_valid), 16'h0000);
    chk(resp.cur_dir, 16'h0000);
    sys_rst  = 1'b0;
    exp_dir  = `CFS_ROOT_ID;
    exp_fv   = 1'b0;
    @(posedge clock);
    #1;
    atr_done = 1'b1;
    @(posedge clock);
    #1;
    atr_done = 1'b0;
    sel(16'h7f60, 1'b1);
    sel(16'h3f00, 1'b1);
    $display("Test second reset done");
    finish_test();
  end
endmodule : card_file_select_record_pointer_tb_top
`default_nettype wire
